// ---- hdl/cafc_defs.vh ----
`ifndef CAFC_DEFS_VH
`define CAFC_DEFS_VH
// register byte addresses
`define CAFC_A_CTRL      8'h00
`define CAFC_A_FILTER    8'h04
`define CAFC_A_MASK      8'h08
`define CAFC_A_SINGLE    8'h0C
`define CAFC_A_PRIO      8'h10
`define CAFC_A_CMD       8'h14
`define CAFC_A_ERRCNT    8'h18
`define CAFC_A_STATUS    8'h1C
`define CAFC_A_IRQ_MASK  8'h20
`define CAFC_A_PROTO     8'h24
`define CAFC_A_VCAL      8'h28
`define CAFC_A_VOLT      8'h2C
`define CAFC_A_REPLY     8'h30
// ctrl bits
`define CAFC_C_FLOW      0
`define CAFC_C_ECHO      1
`define CAFC_C_LEN       2
`define CAFC_C_HDR       3
`define CAFC_C_MON       4
`define CAFC_C_AUTO      5
`define CAFC_C_J1939     6
`define CAFC_C_WIDE      7
// cmd codes (write to CMD register)
`define CAFC_K_DEFAULTS  4'h1
`define CAFC_K_AUTO_RX   4'h2
`define CAFC_K_FAULT_MON 4'h3
`define CAFC_K_DESCRIBE  4'h4
`define CAFC_K_NUMBER    4'h5
`define CAFC_K_ERRSHOW   4'h6
`define CAFC_K_VCAL      4'h7
`define CAFC_K_FLT11     4'h8
`define CAFC_K_FLT29     4'h9
`define CAFC_K_MSK11     4'hA
`define CAFC_K_MSK29     4'hB
`define CAFC_K_SINGLE11  4'hC
`define CAFC_K_SINGLE29  4'hD
// status bits
`define CAFC_S_ACCEPT    0
`define CAFC_S_DISCARD   1
`define CAFC_S_FC_SENT   2
`define CAFC_S_CMD_ERR   3
`define CAFC_S_OFFLINE   4
// resets and widths
`define CAFC_CTRL_RST    8'h07
`define CAFC_FILTER_RST  29'h00000000
`define CAFC_MASK_RST    29'h00000000
`define CAFC_PRIO_RST    5'h18
`define CAFC_VSCALE_RST  16'h1000
`define CAFC_PROTO_RST   4'h0
`define CAFC_ID11        11
`define CAFC_ID29        29
`define CAFC_ERR_OFF     9'h100
`define CAFC_ERR_LIMIT   9'h0FF
`define CAFC_CH_A        8'h41
`define CAFC_CH_O        8'h4F
`define CAFC_CH_F        8'h46
`define CAFC_BRESP_OK    2'b00
`define CAFC_BRESP_ERR   2'b10
`endif

// ---- hdl/cafc_filter.v ----
`timescale 1ns/1ps
`include "cafc_defs.vh"
module cafc_filter
(
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [28:0] rx_id,
  input  wire        rx_id_done,
  input  wire        rx_first_frame,
  input  wire        tx_err_inc,
  input  wire        rx_err_inc,
  input  wire        err_clear,
  input  wire        length_display_default_param,
  input  wire [3:0]  stored_protocol,
  input  wire [15:0] voltage_raw,
  input  wire [7:0]  host_rx_char,
  input  wire        host_rx_valid,
  output reg         rx_accept,
  output reg         rx_discard,
  output reg         fc_send,
  output reg  [7:0]  echo_char,
  output reg         echo_valid,
  output reg  [28:0] tx_id,
  output reg         length_show,
  output reg         fault_mon_active,
  output reg         bus_offline,
  output reg         irq
);

  reg [7:0]  ctrl_q;
  reg [28:0] filter_q;
  reg [28:0] mask_q;
  reg [28:0] single_q;
  reg [4:0]  prio_q;
  reg [4:0]  stat_q;
  reg [4:0]  imask_q;
  reg [3:0]  proto_q;
  reg [15:0] vcal_q;
  reg [15:0] vscale_q;
  reg [31:0] reply_q;
  reg [8:0]  tx_err_q;
  reg [8:0]  rx_err_q;
  reg [7:0]  aw_q;
  reg [31:0] w_q;
  reg [3:0]  ws_q;
  reg        aw_h;
  reg        w_h;
  reg [4:0]  ev;
  wire       wr_go;
  wire       match;
  wire [15:0] vcal_bin;
  wire [31:0] vprod;
  wire [31:0] vquot;

  assign wr_go = aw_h & w_h & ~s_axi_bvalid;
  assign match = ((rx_id ^ filter_q) & mask_q) == 29'h00000000;

  // decimal dd.dd to binary hundredths
  assign vcal_bin = vcal_q[15:12] * 16'd1000 + vcal_q[11:8] * 16'd100
                  + vcal_q[7:4] * 16'd10 + {12'h000, vcal_q[3:0]};
  assign vprod = {16'h0000, vcal_bin} * 32'h00001000;
  // new factor so that raw times factor over 4096 gives the target
  assign vquot = vprod / {16'h0000, voltage_raw};

  always @*
  begin
    ev = 5'h00;
    ev[`CAFC_S_ACCEPT]  = rx_id_done & match;
    ev[`CAFC_S_DISCARD] = rx_id_done & ~match;
    ev[`CAFC_S_FC_SENT] = rx_id_done & match & rx_first_frame
                        & ctrl_q[`CAFC_C_FLOW] & ~ctrl_q[`CAFC_C_MON];
    ev[`CAFC_S_OFFLINE] = (tx_err_q > `CAFC_ERR_LIMIT) & ~bus_offline;
  end

  // write channel capture
  always @(posedge clk)
  begin
    if (rst)
    begin
      aw_h          <= 1'b0;
      w_h           <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CAFC_BRESP_OK;
      aw_q          <= 8'h00;
      w_q           <= 32'h00000000;
      ws_q          <= 4'h0;
    end
    else
    begin
      s_axi_awready <= ~aw_h & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_h & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_h <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_h  <= 1'b1;
        w_q  <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_h         <= 1'b0;
        w_h          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q > `CAFC_A_REPLY) ? `CAFC_BRESP_ERR : `CAFC_BRESP_OK;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers and commands
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q   <= `CAFC_CTRL_RST;
      filter_q <= `CAFC_FILTER_RST;
      mask_q   <= `CAFC_MASK_RST;
      single_q <= 29'h00000000;
      prio_q   <= `CAFC_PRIO_RST;
      imask_q  <= 5'h00;
      proto_q  <= `CAFC_PROTO_RST;
      vcal_q   <= 16'h0000;
      vscale_q <= `CAFC_VSCALE_RST;
      reply_q  <= 32'h00000000;
      fault_mon_active <= 1'b0;
      stat_q   <= 5'h00;
    end
    else
    begin
      stat_q <= stat_q | ev;
      if (wr_go)
      begin
        case (aw_q)
          `CAFC_A_CTRL:     if (ws_q[0]) ctrl_q <= w_q[7:0];
          `CAFC_A_FILTER:   filter_q <= w_q[28:0];
          `CAFC_A_MASK:     mask_q <= w_q[28:0];
          `CAFC_A_SINGLE:   single_q <= w_q[28:0];
          `CAFC_A_PRIO:     if (ws_q[0]) prio_q <= w_q[4:0];
          `CAFC_A_VCAL:     vcal_q <= w_q[15:0];
          `CAFC_A_IRQ_MASK: imask_q <= w_q[4:0];
          `CAFC_A_STATUS:   stat_q <= (stat_q & ~w_q[4:0]) | ev;
          `CAFC_A_CMD:
          begin
            case (w_q[3:0])
              `CAFC_K_DEFAULTS:
              begin
                proto_q  <= stored_protocol;
                filter_q <= `CAFC_FILTER_RST;
                mask_q   <= `CAFC_MASK_RST;
                single_q <= 29'h00000000;
                prio_q   <= `CAFC_PRIO_RST;
                ctrl_q   <= `CAFC_CTRL_RST;
              end
              `CAFC_K_AUTO_RX:
              begin
                filter_q <= `CAFC_FILTER_RST;
                mask_q   <= `CAFC_MASK_RST;
              end
              `CAFC_K_FAULT_MON:
                if (ctrl_q[`CAFC_C_J1939])
                  fault_mon_active <= 1'b1;
                else
                  stat_q[`CAFC_S_CMD_ERR] <= 1'b1;
              `CAFC_K_DESCRIBE:
                reply_q <= {ctrl_q[`CAFC_C_AUTO] ? `CAFC_CH_A : 8'h00, 20'h00000, proto_q};
              `CAFC_K_NUMBER:
                reply_q <= {ctrl_q[`CAFC_C_AUTO] ? `CAFC_CH_A : 8'h00, 20'h00000, proto_q};
              `CAFC_K_ERRSHOW:
                reply_q <= (tx_err_q > `CAFC_ERR_LIMIT)
                         ? {`CAFC_CH_O, `CAFC_CH_F, `CAFC_CH_F, rx_err_q[7:0]}
                         : {8'h00, tx_err_q[7:0], 8'h00, rx_err_q[7:0]};
              `CAFC_K_VCAL:
                if (voltage_raw != 16'h0000)
                  vscale_q <= vquot[15:0];
              `CAFC_K_FLT11:   filter_q <= {18'h00000, w_q[26:16]};
              `CAFC_K_FLT29:   filter_q <= single_q;
              `CAFC_K_MSK11:   mask_q <= {18'h00000, single_q[10:0]};
              `CAFC_K_MSK29:   mask_q <= single_q;
              `CAFC_K_SINGLE11:
              begin
                filter_q <= {18'h00000, single_q[10:0]};
                mask_q   <= {18'h00000, 11'h7FF};
              end
              `CAFC_K_SINGLE29:
              begin
                filter_q <= single_q;
                mask_q   <= 29'h1FFFFFFF;
              end
              default: reply_q <= reply_q;
            endcase
          end
          default: reply_q <= reply_q;
        endcase
      end
    end
  end

  // error counters
  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_err_q    <= 9'h000;
      rx_err_q    <= 9'h000;
      bus_offline <= 1'b0;
    end
    else if (err_clear)
    begin
      tx_err_q    <= 9'h000;
      rx_err_q    <= 9'h000;
      bus_offline <= 1'b0;
    end
    else
    begin
      if (tx_err_inc & (tx_err_q != `CAFC_ERR_OFF))
        tx_err_q <= tx_err_q + 9'h001;
      if (rx_err_inc & (rx_err_q != `CAFC_ERR_LIMIT))
        rx_err_q <= rx_err_q + 9'h001;
      if (tx_err_q > `CAFC_ERR_LIMIT)
        bus_offline <= 1'b1;
    end
  end

  // receive decisions and echo
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx_accept   <= 1'b0;
      rx_discard  <= 1'b0;
      fc_send     <= 1'b0;
      echo_char   <= 8'h00;
      echo_valid  <= 1'b0;
      tx_id       <= 29'h00000000;
      length_show <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      rx_accept  <= ev[`CAFC_S_ACCEPT];
      rx_discard <= ev[`CAFC_S_DISCARD];
      fc_send    <= ev[`CAFC_S_FC_SENT];
      echo_valid <= host_rx_valid & ctrl_q[`CAFC_C_ECHO];
      if (host_rx_valid)
        echo_char <= host_rx_char;
      tx_id       <= {prio_q, single_q[23:0]};
      length_show <= (ctrl_q[`CAFC_C_LEN] ^ length_display_default_param)
                   & ctrl_q[`CAFC_C_HDR];
      irq         <= |(stat_q & imask_q);
    end
  end

  // read channel
  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CAFC_BRESP_OK;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CAFC_BRESP_OK;
        case (s_axi_araddr)
          `CAFC_A_CTRL:     s_axi_rdata <= {24'h000000, ctrl_q};
          `CAFC_A_FILTER:   s_axi_rdata <= {3'b000, filter_q};
          `CAFC_A_MASK:     s_axi_rdata <= {3'b000, mask_q};
          `CAFC_A_SINGLE:   s_axi_rdata <= {3'b000, single_q};
          `CAFC_A_PRIO:     s_axi_rdata <= {27'h0000000, prio_q};
          `CAFC_A_CMD:      s_axi_rdata <= {31'h00000000, fault_mon_active};
          `CAFC_A_ERRCNT:   s_axi_rdata <= {7'h00, tx_err_q, 7'h00, rx_err_q};
          `CAFC_A_STATUS:   s_axi_rdata <= {27'h0000000, stat_q};
          `CAFC_A_IRQ_MASK: s_axi_rdata <= {27'h0000000, imask_q};
          `CAFC_A_PROTO:    s_axi_rdata <= {28'h0000000, proto_q};
          `CAFC_A_VCAL:     s_axi_rdata <= {vscale_q, vcal_q};
          `CAFC_A_VOLT:     s_axi_rdata <= {16'h0000, voltage_raw};
          `CAFC_A_REPLY:    s_axi_rdata <= reply_q;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CAFC_BRESP_ERR;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- dv/cafc_properties.sv ----
`timescale 1ns/1ps
module cafc_properties
(
  input wire       clk,
  input wire       rst,
  input wire       rx_id_done,
  input wire       rx_first_frame,
  input wire       tx_err_inc,
  input wire       err_clear,
  input wire [7:0] host_rx_char,
  input wire       host_rx_valid,
  input wire       rx_accept,
  input wire       rx_discard,
  input wire       fc_send,
  input wire [7:0] echo_char,
  input wire       echo_valid,
  input wire       bus_offline,
  input wire       length_show,
  input wire       s_axi_bvalid,
  input wire       length_display_default_param
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_one_verdict: assert property (rx_id_done |=> rx_accept != rx_discard)
    else $error("verdict not exclusive");
  chk_verdict_late: assert property (!rx_id_done |=> !(rx_accept || rx_discard))
    else $error("verdict without id");
  chk_fc_accept: assert property (fc_send |-> rx_accept)
    else $error("fc on discard");
  chk_fc_first: assert property (fc_send |-> $past(rx_first_frame))
    else $error("fc without first frame");
  chk_echo_copy: assert property (
    echo_valid |-> $past(host_rx_valid) && echo_char == $past(host_rx_char))
    else $error("echo mismatch");
  chk_offline_cause: assert property (
    $rose(bus_offline) |-> $past(tx_err_inc) || $past(tx_err_inc, 2))
    else $error("offline without tx error");
  chk_offline_clear: assert property (err_clear |-> ##2 !bus_offline)
    else $error("offline after clear");
  chk_len_source: assert property (
    $changed(length_show) |-> $past(s_axi_bvalid) || $past(rst, 2)
      || ($past(length_display_default_param) != $past(length_display_default_param, 2)))
    else $error("length display changed without cause");
  cover property (fc_send);
  cover property (rx_discard);
  cover property (echo_valid);
  cover property (bus_offline);
endmodule
bind cafc_filter cafc_properties u_chk (.*);

// ---- dv/cafc_can_node.sv ----
`timescale 1ns/1ps
module cafc_can_node
(
  input  wire        clk,
  output reg  [28:0] rx_id,
  output reg         rx_id_done,
  output reg         rx_first_frame
);
  initial
  begin
    rx_id = 29'h0;
    rx_id_done = 1'h0;
    rx_first_frame = 1'h0;
  end
  // one complete identifier, lines scrambled once done
  task send(input [28:0] id, input ff);
    begin
      @(posedge clk);
      rx_id <= id;
      rx_first_frame <= ff;
      rx_id_done <= 1'h1;
      @(posedge clk);
      rx_id <= ~id;
      rx_first_frame <= ~ff;
      rx_id_done <= 1'h0;
    end
  endtask
endmodule

// ---- dv/cafc_filter_tb.sv ----
`timescale 1ns/1ps
module cafc_filter_tb;
  reg         clk = 1'h0, rst = 1'h1;
  reg  [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, host_rx_char = 8'h0;
  reg  [31:0] s_axi_wdata = 32'h0, d;
  reg  [3:0]  s_axi_wstrb = 4'hF, stored_protocol = 4'h6;
  reg  [15:0] voltage_raw = 16'h0400;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, host_rx_valid = 1'h0;
  reg         tx_err_inc = 1'h0, rx_err_inc = 1'h0, err_clear = 1'h0;
  reg         length_display_default_param = 1'h0;
  reg  [1:0]  r;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        rx_id_done, rx_first_frame, rx_accept, rx_discard, fc_send, echo_valid;
  wire        length_show, fault_mon_active, bus_offline, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [28:0] rx_id, tx_id;
  wire [7:0]  echo_char;
  integer     error_cnt = 0, compares = 0, n;
  always #5 clk = ~clk;
  cafc_filter dut (.*);
  cafc_can_node node (.*);
  task ck(input string nm, input [31:0] e, input [31:0] s);
    begin
      compares = compares + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && compares > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n = n + 1)
      begin
        @(posedge clk);
        if (s_axi_awready === 1'h1)
          s_axi_awvalid <= 1'h0;
        if (s_axi_wready === 1'h1)
          s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid === 1'h1)
        begin
          r = s_axi_bresp;
          s_axi_bready <= 1'h0;
          n = 99;
        end
      end
      if (n == 40)
        hang;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n = n + 1)
      begin
        @(posedge clk);
        if (s_axi_arready === 1'h1)
          s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid === 1'h1)
        begin
          d = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 1'h0;
          n = 99;
        end
      end
      if (n == 40)
        hang;
    end
  endtask
  task hang;
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  endtask
  task rk(input string nm, input [7:0] a, input [31:0] e);
    begin
      rd(a);
      ck(nm, e, d);
    end
  endtask
  // f = {first frame, accepted, flow control}
  task frm(input [28:0] id, input [2:0] f);
    begin
      node.send(id, f[2]);
      #1;
      ck("accept", f[1], rx_accept);
      ck("discard", !f[1], rx_discard);
      ck("fc_send", f[0], fc_send);
    end
  endtask
  task pulse(input integer k, input [2:0] w);
    begin
      repeat (k)
      begin
        @(posedge clk);
        {err_clear, rx_err_inc, tx_err_inc} <= w;
        @(posedge clk);
        {err_clear, rx_err_inc, tx_err_inc} <= 3'h0;
      end
    end
  endtask
  task echo(input [7:0] c, input e);
    begin
      @(posedge clk);
      host_rx_char <= c;
      host_rx_valid <= 1'h1;
      @(posedge clk);
      host_rx_valid <= 1'h0;
      #1;
      ck("echo_valid", e, echo_valid);
      if (e)
        ck("echo_char", c, echo_char);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rk("ctrl", 8'h00, 32'h07);
    rk("prio", 8'h10, 32'h18);
    frm(29'h1ABCDEF3, 3'h7);
    wr(8'h10, 32'hFF);
    wr(8'h0C, 32'h00ABCDEF);
    rk("prio", 8'h10, 32'h1F);
    ck("tx_id", 32'h1FABCDEF, tx_id);
    wr(8'h04, 32'hFFFFFFFF);
    rk("filter", 8'h04, 32'h1FFFFFFF);
    wr(8'h14, 32'h0FE80008);
    rk("filter", 8'h04, 32'h7E8);
    wr(8'h0C, 32'hFFF);
    wr(8'h14, 32'hA);
    rk("mask", 8'h08, 32'h7FF);
    frm(29'h7E8, 3'h2);
    frm(29'h7E9, 3'h4);
    frm(29'h1F0007E8, 3'h7);
    wr(8'h0C, 32'hFFFFFFFF);
    wr(8'h14, 32'hB);
    rk("mask", 8'h08, 32'h1FFFFFFF);
    wr(8'h0C, 32'hE00007E8);
    wr(8'h14, 32'h9);
    rk("filter", 8'h04, 32'h7E8);
    frm(29'h100007E8, 3'h0);
    wr(8'h00, 32'h06);
    frm(29'h7E8, 3'h6);
    wr(8'h00, 32'h17);
    frm(29'h7E8, 3'h6);
    wr(8'h0C, 32'h123);
    wr(8'h14, 32'hC);
    rk("mask", 8'h08, 32'h7FF);
    rk("filter", 8'h04, 32'h123);
    frm(29'h124, 3'h0);
    wr(8'h0C, 32'h18DAF110);
    wr(8'h14, 32'hD);
    rk("mask", 8'h08, 32'h1FFFFFFF);
    wr(8'h14, 32'h2);
    rk("mask", 8'h08, 32'h0);
    frm(29'h124, 3'h2);
    wr(8'h00, 32'h05);
    echo(8'h3C, 1'h0);
    wr(8'h00, 32'h07);
    echo(8'h5A, 1'h1);
    ck("len", 1'h0, length_show);
    wr(8'h00, 32'h0F);
    rk("ctrl", 8'h00, 32'h0F);
    ck("len", 1'h1, length_show);
    @(posedge clk);
    length_display_default_param <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    ck("len", 1'h0, length_show);
    wr(8'h1C, 32'h1F);
    wr(8'h20, 32'h10);
    pulse(255, 3'h1);
    pulse(3, 3'h2);
    wr(8'h14, 32'h6);
    rk("reply", 8'h30, 32'h00FF0003);
    ck("offline", 1'h0, bus_offline);
    pulse(1, 3'h1);
    wr(8'h14, 32'h6);
    rk("reply", 8'h30, 32'h4F464603);
    rk("errcnt", 8'h18, 32'h01000003);
    ck("offline", 1'h1, bus_offline);
    ck("irq", 1'h1, irq);
    wr(8'h20, 32'h0);
    rk("status", 8'h1C, 32'h10);
    ck("irq", 1'h0, irq);
    pulse(1, 3'h4);
    wr(8'h1C, 32'h10);
    rk("status", 8'h1C, 32'h0);
    ck("offline", 1'h0, bus_offline);
    wr(8'h14, 32'h3);
    rk("status", 8'h1C, 32'h08);
    ck("fmon", 1'h0, fault_mon_active);
    wr(8'h00, 32'h47);
    wr(8'h14, 32'h3);
    rk("cmd", 8'h14, 32'h1);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h1);
    rk("proto", 8'h24, 32'h6);
    rk("filter", 8'h04, 32'h0);
    rk("prio", 8'h10, 32'h18);
    rk("single", 8'h0C, 32'h0);
    wr(8'h14, 32'h4);
    rk("describe", 8'h30, 32'h6);
    wr(8'h00, 32'h27);
    wr(8'h14, 32'h5);
    rk("number", 8'h30, 32'h41000006);
    wr(8'h28, 32'h1199);
    wr(8'h14, 32'h7);
    rk("vcal", 8'h28, 32'h12BC1199);
    wr(8'h40, 32'h1);
    ck("bresp", 2'h2, r);
    rk("rdata", 8'h40, 32'h0);
    ck("rresp", 2'h2, r);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rk("ctrl", 8'h00, 32'h07);
    rk("vcal", 8'h28, 32'h10000000);
    report_and_stop;
  end
endmodule
